// *** rtl/counter_pulse_mode_control.sv ***
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "cpmc_cfg.svh"

// How it works
// - Port 0000/0001 is pulse output, 0010-0015 counters 0-5, 1000 is PWM.
// - Codes: 0000 start compare, 0001 stop compare, 0002 load value, 0003 stop output.
// - Pulse ports: load, stop; counters: start, stop compare, load; PWM: stop only.
// - A forbidden port and code pairing sets the fault flag and does nothing.
// - Out-of-range port or code sets the fault flag; the new value is never range-checked.
// - The two new-value words are used only by the load code.
// - Start compare enables comparing the counter against its target table.
// - Start compare without a registered table sets the fault flag.
// - Stop compare disables comparing for the selected counter.
// - Loading a pulse output that is running sets the fault flag.
// - Loading a counter port not set up as counter sets the fault flag.
// - Pulse outputs and signed-mode counters take the value as signed 32-bit.
// - Increment-only and ring-mode counters take the value as unsigned 32-bit.
// - Stop output halts the pulse or PWM port at once, no deceleration.
// - Stop output on an already halted port clears its pulse amount.
// - A command from an ISR that broke a table registration sets the fault flag.
// - A command with no fault condition clears the fault flag.
module counter_pulse_mode_control (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [5:0]  tableRegistered,
  input  wire logic [5:0]  counterConfigured,
  input  wire logic [5:0]  counterSignedMode,
  input  wire logic [2:0]  pulseActive,
  input  wire logic        isrBrokeTableReg,
  output logic [5:0]       compareEnable,
  output logic             pvLoadStrobe,
  output logic [3:0]       pvLoadPort,
  output logic             pvLoadSigned,
  output logic [31:0]      pvLoadValue,
  output logic [2:0]       stopOutputStrobe,
  output logic [2:0]       clearAmountStrobe,
  output logic             irq
);

  cpmc_pkg::cpmc_state_t st_ff;
  cpmc_pkg::cpmc_state_t nxt_st;

  // ==========================================================================
  // Port decode
  // ==========================================================================
  cpmc_pkg::cpmc_port_class_t portClass;
  logic [3:0]                 portIdx;

  always_comb begin
    portClass = cpmc_pkg::PC_INVALID;
    portIdx   = 4'h0;
    if (st_ff.port == `CPMC_PORT_PULSE0 || st_ff.port == `CPMC_PORT_PULSE1) begin
      portClass = cpmc_pkg::PC_PULSE;
      portIdx   = st_ff.port[3:0];
    end else if (st_ff.port >= `CPMC_PORT_CNT_FIRST && st_ff.port <= `CPMC_PORT_CNT_LAST) begin
      portClass = cpmc_pkg::PC_COUNTER;
      portIdx   = st_ff.port[3:0];
    end else if (st_ff.port == `CPMC_PORT_PWM) begin
      portClass = cpmc_pkg::PC_PWM;
      portIdx   = 4'h2;
    end
  end

  // ==========================================================================
  // Command checks
  // ==========================================================================
  logic comboOk;
  logic codeOk;
  logic condFault;
  logic cmdFault;
  logic outRunning;

  always_comb begin
    codeOk     = (st_ff.code <= `CPMC_CODE_STOP_OUT);
    comboOk    = 1'b0;
    condFault  = 1'b0;
    outRunning = pulseActive[portIdx[1:0]];
    case (portClass)
      cpmc_pkg::PC_PULSE: begin
        comboOk = (st_ff.code == `CPMC_CODE_LOAD_PV) ||
                  (st_ff.code == `CPMC_CODE_STOP_OUT);
        if (st_ff.code == `CPMC_CODE_LOAD_PV && outRunning) begin
          condFault = 1'b1;
        end
      end
      cpmc_pkg::PC_COUNTER: begin
        comboOk = (st_ff.code == `CPMC_CODE_START_CMP) ||
                  (st_ff.code == `CPMC_CODE_STOP_CMP) ||
                  (st_ff.code == `CPMC_CODE_LOAD_PV);
        if (st_ff.code == `CPMC_CODE_START_CMP && !tableRegistered[portIdx[2:0]]) begin
          condFault = 1'b1;
        end
        if (st_ff.code == `CPMC_CODE_LOAD_PV && !counterConfigured[portIdx[2:0]]) begin
          condFault = 1'b1;
        end
      end
      cpmc_pkg::PC_PWM: begin
        comboOk = (st_ff.code == `CPMC_CODE_STOP_OUT);
      end
      default: begin
        comboOk = 1'b0;
      end
    endcase
    // The full 32-bit pattern space is legal in both signed and unsigned
    // interpretation, so the new value itself can never be out of range.
    cmdFault = !codeOk || !comboOk || condFault || isrBrokeTableReg;
  end

  // ==========================================================================
  // APB slave, command execution and interrupts
  // ==========================================================================
  logic        access;
  logic        wrAcc;
  logic        go;
  logic [7:0]  addr;
  logic        mapped;
  logic [31:0] rdData;
  logic [1:0]  intSet;

  always_comb begin
    nxt_st = st_ff;
    addr   = paddr[7:0];
    // One wait state: the answer is registered, so pready rises a cycle late.
    access = psel && penable && !st_ff.pready;
    wrAcc  = access && pwrite;
    mapped = (paddr[31:8] == 24'h000000) && (addr[1:0] == 2'h0) &&
             (addr <= `CPMC_OFF_INT_MASK);
    go     = wrAcc && mapped && (addr == `CPMC_OFF_CTRL) && pwdata[`CPMC_CTRL_GO_BIT];
    intSet = 2'h0;

    nxt_st.pready  = access;
    nxt_st.pslverr = access && !mapped;
    nxt_st.loadStb = 1'b0;
    nxt_st.stopStb = 3'h0;
    nxt_st.clrStb  = 3'h0;

    rdData = 32'h00000000;
    case (addr)
      `CPMC_OFF_PORT:       rdData = {16'h0000, st_ff.port};
      `CPMC_OFF_CODE:       rdData = {16'h0000, st_ff.code};
      `CPMC_OFF_NV_LO:      rdData = {16'h0000, st_ff.nvLo};
      `CPMC_OFF_NV_HI:      rdData = {16'h0000, st_ff.nvHi};
      `CPMC_OFF_STATUS:     rdData = {18'h00000, st_ff.cmpEn, 7'h00, st_ff.fault};
      `CPMC_OFF_INT_STATUS: rdData = {30'h00000000, st_ff.intSt};
      `CPMC_OFF_INT_MASK:   rdData = {30'h00000000, st_ff.intMask};
      default:              rdData = 32'h00000000;
    endcase
    nxt_st.prdata = (access && !pwrite && mapped) ? rdData : 32'h00000000;

    if (wrAcc && mapped) begin
      case (addr)
        `CPMC_OFF_PORT:     nxt_st.port    = pwdata[15:0];
        `CPMC_OFF_CODE:     nxt_st.code    = pwdata[15:0];
        `CPMC_OFF_NV_LO:    nxt_st.nvLo    = pwdata[15:0];
        `CPMC_OFF_NV_HI:    nxt_st.nvHi    = pwdata[15:0];
        `CPMC_OFF_INT_MASK: nxt_st.intMask = pwdata[1:0];
        default: begin
        end
      endcase
    end

    if (go) begin
      intSet[`CPMC_INT_DONE_BIT] = 1'b1;
      if (cmdFault) begin
        nxt_st.fault                = 1'b1;
        intSet[`CPMC_INT_FAULT_BIT] = 1'b1;
      end else begin
        nxt_st.fault = 1'b0;
        case (st_ff.code)
          `CPMC_CODE_START_CMP: nxt_st.cmpEn[portIdx[2:0]] = 1'b1;
          `CPMC_CODE_STOP_CMP:  nxt_st.cmpEn[portIdx[2:0]] = 1'b0;
          `CPMC_CODE_LOAD_PV: begin
            nxt_st.loadStb    = 1'b1;
            nxt_st.loadPort   = portIdx;
            nxt_st.loadVal    = {st_ff.nvHi, st_ff.nvLo};
            nxt_st.loadSigned = (portClass == cpmc_pkg::PC_PULSE) ||
                                counterSignedMode[portIdx[2:0]];
          end
          `CPMC_CODE_STOP_OUT: begin
            if (outRunning) begin
              nxt_st.stopStb[portIdx[1:0]] = 1'b1;
            end else begin
              nxt_st.clrStb[portIdx[1:0]] = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Write-one-to-clear, but a new event in the same cycle wins.
    if (wrAcc && mapped && addr == `CPMC_OFF_INT_STATUS) begin
      nxt_st.intSt = (st_ff.intSt & ~pwdata[1:0]) | intSet;
    end else begin
      nxt_st.intSt = st_ff.intSt | intSet;
    end
    nxt_st.irq = |(nxt_st.intSt & nxt_st.intMask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff         <= '0;
      st_ff.port    <= `CPMC_RST_WORD;
      st_ff.code    <= `CPMC_RST_WORD;
      st_ff.intMask <= `CPMC_RST_MASK;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pready            = st_ff.pready;
  assign prdata            = st_ff.prdata;
  assign pslverr           = st_ff.pslverr;
  assign compareEnable     = st_ff.cmpEn;
  assign pvLoadStrobe      = st_ff.loadStb;
  assign pvLoadPort        = st_ff.loadPort;
  assign pvLoadSigned      = st_ff.loadSigned;
  assign pvLoadValue       = st_ff.loadVal;
  assign stopOutputStrobe  = st_ff.stopStb;
  assign clearAmountStrobe = st_ff.clrStb;
  assign irq               = st_ff.irq;

endmodule

// *** rtl/cpmc_cfg.svh ***
`ifndef CPMC_CFG_SVH
`define CPMC_CFG_SVH

// ==========================================================================
// Register offsets (byte addresses, one aligned word each)
// ==========================================================================
`define CPMC_ADDR_W          8
`define CPMC_OFF_PORT        8'h00
`define CPMC_OFF_CODE        8'h04
`define CPMC_OFF_NV_LO       8'h08
`define CPMC_OFF_NV_HI       8'h0C
`define CPMC_OFF_CTRL        8'h10
`define CPMC_OFF_STATUS      8'h14
`define CPMC_OFF_INT_STATUS  8'h18
`define CPMC_OFF_INT_MASK    8'h1C

// ==========================================================================
// Field positions
// ==========================================================================
`define CPMC_CTRL_GO_BIT     0
`define CPMC_ST_FAULT_BIT    0
`define CPMC_ST_CMP_LSB      8
`define CPMC_INT_DONE_BIT    0
`define CPMC_INT_FAULT_BIT   1

// ==========================================================================
// Port specifiers and control codes
// ==========================================================================
`define CPMC_PORT_PULSE0     16'h0000
`define CPMC_PORT_PULSE1     16'h0001
`define CPMC_PORT_CNT_FIRST  16'h0010
`define CPMC_PORT_CNT_LAST   16'h0015
`define CPMC_PORT_PWM        16'h1000
`define CPMC_CODE_START_CMP  16'h0000
`define CPMC_CODE_STOP_CMP   16'h0001
`define CPMC_CODE_LOAD_PV    16'h0002
`define CPMC_CODE_STOP_OUT   16'h0003

// ==========================================================================
// Reset values
// ==========================================================================
`define CPMC_RST_WORD        16'h0000
`define CPMC_RST_MASK        2'h0

`endif

// *** rtl/cpmc_pkg.sv ***
package cpmc_pkg;

  typedef enum logic [1:0] {
    PC_PULSE,
    PC_COUNTER,
    PC_PWM,
    PC_INVALID
  } cpmc_port_class_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [15:0] port;
    logic [15:0] code;
    logic [15:0] nvLo;
    logic [15:0] nvHi;
    logic        fault;
    logic [5:0]  cmpEn;
    logic        loadStb;
    logic [3:0]  loadPort;
    logic        loadSigned;
    logic [31:0] loadVal;
    logic [2:0]  stopStb;
    logic [2:0]  clrStb;
    logic [1:0]  intSt;
    logic [1:0]  intMask;
    logic        irq;
  } cpmc_state_t;

endpackage

// *** tb/counter_pulse_mode_control_test.sv ***
`timescale 1ns/1ps
// ==========================================================
// Bench for the mode-control block
module counter_pulse_mode_control_test;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        isrBrokeTableReg = 1'b0, pready, pslverr, irq, err, pvLoadStrobe, pvLoadSigned;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, expVal = 32'h0, seed = 32'h2390;
  logic [31:0] prdata, pvLoadValue, rd;
  logic [5:0]  tableRegistered = 6'h0, counterConfigured = 6'h0, counterSignedMode = 6'h0;
  logic [5:0]  expCe = 6'h0, compareEnable;
  logic [4:0]  expLd = 5'h0;
  logic [3:0]  pvLoadPort;
  logic [2:0]  startReq = 3'h0, pulseActive, stopOutputStrobe, clearAmountStrobe;
  logic [6:0]  stb;
  int          failCount = 0, numChecks = 0;
  localparam logic [15:0] PTAB [12] = '{16'h0000, 16'h0001, 16'h0010, 16'h0011, 16'h0012,
    16'h0013, 16'h0014, 16'h0015, 16'h1000, 16'h0002, 16'h0016, 16'h1001};

  counter_pulse_mode_control uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .tableRegistered, .counterConfigured, .counterSignedMode,
    .pulseActive, .isrBrokeTableReg, .compareEnable, .pvLoadStrobe, .pvLoadPort,
    .pvLoadSigned, .pvLoadValue, .stopOutputStrobe, .clearAmountStrobe, .irq);
  cpmc_pulse_model far (.clk, .rst, .startReq, .stopOutputStrobe, .pulseActive);

  initial begin
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Returns {fault, load, stop[2:0], clear[2:0]} for the current conditions.
  function automatic logic [7:0] exp_cmd(input logic [15:0] p, input logic [15:0] c);
    logic       pu, cn, ok, st;
    logic [1:0] b;
    pu = p < 16'h0002;
    cn = p >= 16'h0010 && p <= 16'h0015;
    b = p == 16'h1000 ? 2'h2 : {1'b0, p[0]};
    ok = pu ? c == 16'h0002 || c == 16'h0003 : cn ? c < 16'h0003 : p == 16'h1000 && c == 16'h0003;
    ok = ok && !isrBrokeTableReg && !(cn && c == 16'h0000 && !tableRegistered[p[2:0]]);
    ok = ok && !(pu && c == 16'h0002 && pulseActive[b]);
    ok = ok && !(cn && c == 16'h0002 && !counterConfigured[p[2:0]]);
    st = ok && c == 16'h0003;
    return {!ok, ok && c == 16'h0002, (st && pulseActive[b]) ? 3'h1 << b : 3'h0,
      (st && !pulseActive[b]) ? 3'h1 << b : 3'h0};
  endfunction

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] want);
    numChecks++;
    if (seen !== want) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", n, want, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      chk("pready", 32'h0, 32'h1);
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    stb = {pvLoadStrobe, stopOutputStrobe, clearAmountStrobe};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [15:0] p, input logic [15:0] c);
    logic [31:0] nv, m;
    logic [7:0]  e;
    nv = rnd();
    m = rnd() & 32'h3;
    apb(1'b1, 32'h0, {16'h0, p});
    apb(1'b1, 32'h4, {16'h0, c});
    apb(1'b1, 32'h8, {16'h0, nv[15:0]});
    apb(1'b1, 32'hC, {16'h0, nv[31:16]});
    apb(1'b1, 32'h1C, m);
    e = exp_cmd(p, c);
    apb(1'b1, 32'h10, 32'h1);
    chk("strobes", {25'h0, stb}, {25'h0, e[6:0]});
    if (e[6]) begin
      expVal = nv;
      expLd = {p[4] ? counterSignedMode[p[2:0]] : 1'b1, p[3:0]};
    end
    if (!e[7] && c < 16'h0002) expCe[p[2:0]] = c == 16'h0000;
    chk("compareEnable", {26'h0, compareEnable}, {26'h0, expCe});
    chk("value", pvLoadValue, expVal);
    chk("loadPort", {27'h0, pvLoadSigned, pvLoadPort}, {27'h0, expLd});
    apb(1'b0, 32'h14, 32'h0);
    chk("status", rd, {18'h0, expCe, 7'h0, e[7]});
    apb(1'b0, 32'h18, 32'h0);
    chk("intStatus", rd, {30'h0, e[7], 1'b1});
    chk("irq", {31'h0, irq}, {31'h0, |({e[7], 1'b1} & m[1:0])});
    apb(1'b1, 32'h18, 32'h3);
    apb(1'b0, 32'h18, 32'h0);
    chk("intClear", {rd[30:0], irq}, 32'h0);
  endtask

  initial begin
    logic [31:0] r;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 32'h0, 32'h0);
    chk("portReset", rd, 32'h0);
    apb(1'b0, 32'h20, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b1, 32'h6, 32'h1);
    chk("misaligned", {31'h0, err}, 32'h1);
    $display("test bus done");
    // The first 48 commands sweep every port against every code with no interrupt conflict.
    for (int i = 0; i < 110; i++) begin
      r = rnd();
      tableRegistered <= r[5:0];
      counterConfigured <= r[11:6];
      counterSignedMode <= r[17:12];
      startReq <= i < 48 ? 3'h0 : r[20:18] & r[23:21];
      isrBrokeTableReg <= i >= 48 && r[26:24] == 3'h0;
      @(posedge clk);
      startReq <= 3'h0;
      if (i < 48) cmd(PTAB[i / 4], 16'(i % 4));
      else cmd(PTAB[r[31:27] % 12], {13'h0, r[29:27]});
    end
    $display("test commands done");
    tally_and_finish();
  end
endmodule

// *** tb/cpmc_assertions.sv ***
`timescale 1ns/1ps
// ==========================================================
// Port checker for the mode-control block
module cpmc_checker (
  input logic        clk,
  input logic        rst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic [2:0]  pulseActive,
  input logic        isrBrokeTableReg,
  input logic [5:0]  compareEnable,
  input logic        pvLoadStrobe,
  input logic [3:0]  pvLoadPort,
  input logic [2:0]  stopOutputStrobe,
  input logic [2:0]  clearAmountStrobe,
  input logic        irq
);
  logic [15:0] port_ff;
  logic [15:0] code_ff;
  wire         wr = psel && penable && !pready && pwrite;
  wire         go = wr && paddr == 32'h10 && pwdata[0];
  wire         pls = go && port_ff[15:1] == 15'h0 && code_ff == 16'h0002;
  // Shadow the stored operands, because a command acts on them long after they were written.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port_ff <= 16'h0;
      code_ff <= 16'h0;
    end else if (wr && paddr == 32'h0) begin
      port_ff <= pwdata[15:0];
    end else if (wr && paddr == 32'h4) begin
      code_ff <= pwdata[15:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_ACCESS_READY: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_LOAD_CAUSE: assert property (pvLoadStrobe |-> $past(go) && $past(code_ff) == 16'h0002)
    else $error("stray load");
  AST_STOP_CAUSE: assert property ((stopOutputStrobe | clearAmountStrobe) != 3'h0 |->
    $past(go) && $past(code_ff) == 16'h0003) else $error("stray stop");
  AST_PWM_STOP: assert property (go && port_ff == 16'h1000 && code_ff == 16'h0003 &&
    !isrBrokeTableReg |=> stopOutputStrobe == {$past(pulseActive[2]), 2'h0} &&
    clearAmountStrobe == {!$past(pulseActive[2]), 2'h0}) else $error("pwm stop");
  AST_ISR_QUIET: assert property (go && isrBrokeTableReg |=> !pvLoadStrobe &&
    stopOutputStrobe == 3'h0 && $stable(compareEnable)) else $error("isr action");
  AST_PULSE_LOAD: assert property (pls && !pulseActive[port_ff[0]] && !isrBrokeTableReg
    |=> pvLoadStrobe && pvLoadPort == {3'h0, port_ff[0]}) else $error("pulse load");
  AST_PULSE_BUSY: assert property (pls && pulseActive[port_ff[0]] |=> !pvLoadStrobe)
    else $error("busy load");
  AST_CMP_HOLD: assert property (!go |=> $stable(compareEnable))
    else $error("compare moved");
  cover property (go && code_ff == 16'h0002);
  cover property (clearAmountStrobe != 3'h0);
  cover property (irq);
endmodule

bind counter_pulse_mode_control cpmc_checker chk (.clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pulseActive, .isrBrokeTableReg, .compareEnable, .pvLoadStrobe,
  .pvLoadPort, .stopOutputStrobe, .clearAmountStrobe, .irq);

// *** tb/cpmc_pulse_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// Pulse and PWM generators beside the block
module cpmc_pulse_model (
  input  logic       clk,
  input  logic       rst,
  input  logic [2:0] startReq,
  input  logic [2:0] stopOutputStrobe,
  output logic [2:0] pulseActive
);
  logic [2:0] act_ff;
  logic [2:0] nxt_act;
  // A halt beats a start in the same cycle, since there is no ramp-down.
  always_comb nxt_act = (act_ff | startReq) & ~stopOutputStrobe;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_ff <= 3'h0;
    end else begin
      act_ff <= nxt_act;
    end
  end
  assign pulseActive = act_ff;
endmodule
